// ---- rtl/copor_top.v ----
/*
 * Clock output and PLL override register block: three configuration
 * registers behind the serial register port, the auxiliary event output
 * generator and the PLL pin/register override multiplexer.
 * Assumes the serializer supplies a one-cycle pulse every 8 UI on clk_sys
 * and a reinit level; pins reach this block asynchronously.
 */
`timescale 1ns/1ps
`include "copor_regs.vh"

module copor_top (
  // Clock and reset
  input wire clk_sys,
  input wire arst_n,
  // Serial register port
  input wire spi_sclk,
  input wire spi_cs_n,
  input wire spi_sdi,
  output wire spi_sdo,
  output wire spi_sdo_oe,
  // Serializer timing
  input wire ser_tick_8ui,
  input wire ser_reinit,
  // Timestamp input pin
  input wire timestamp_input,
  // Auxiliary event output pair
  output wire event_output_pair_p,
  output wire event_output_pair_n,
  output wire event_output_drive,
  // PLL configuration pins
  input wire pll_enable_pin,
  input wire single_ended_ref_pin,
  input wire clock_config_pin_a,
  input wire clock_config_pin_b,
  // Calibration engine
  input wire oscillator_calibration_enable,
  input wire oscillator_calibration_done,
  input wire cal_trim_wr,
  input wire [6:0] cal_trim_value,
  // PLL controls
  output reg pll_enable,
  output reg single_ended_ref_input_sel,
  output reg [1:0] divided_ref_out_c_sel,
  output reg [1:0] divided_ref_out_d_sel,
  output wire [6:0] oscillator_frequency_trim
);

  wire [14:0] reg_addr;
  wire reg_wr;
  wire [7:0] reg_wdata;
  reg [7:0] reg_rdata;

  reg [7:0] evt_ctrl_q;
  reg [7:0] pll_ovr_q;
  reg [6:0] trim_q;
  localparam [7:0] trim_rst_val = `COPOR_RST_OSC_TRIM;

  copor_spi_slave u_spi (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n),
    .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo),
    .spi_sdo_oe(spi_sdo_oe),
    .reg_addr_q(reg_addr),
    .reg_wr_q(reg_wr),
    .reg_wdata_q(reg_wdata),
    .reg_rdata(reg_rdata)
  );

  // Register file
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      evt_ctrl_q <= `COPOR_RST_EVT_CTRL;
      pll_ovr_q <= `COPOR_RST_PLL_OVR;
      trim_q <= trim_rst_val[6:0];
    end else begin
      if (reg_wr && reg_addr == `COPOR_ADDR_EVT_CTRL) begin
        evt_ctrl_q <= reg_wdata & `COPOR_EVT_WMASK;
      end
      if (reg_wr && reg_addr == `COPOR_ADDR_PLL_OVR) begin
        pll_ovr_q <= reg_wdata & `COPOR_OVR_WMASK;
      end
      // Engine update wins over a colliding host write
      if (cal_trim_wr) begin
        trim_q <= cal_trim_value;
      end else if (reg_wr && reg_addr == `COPOR_ADDR_OSC_TRIM) begin
        trim_q <= reg_wdata[6:0];
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always @* begin
    case (reg_addr)
      `COPOR_ADDR_EVT_CTRL: reg_rdata = evt_ctrl_q;
      `COPOR_ADDR_PLL_OVR: reg_rdata = pll_ovr_q;
      `COPOR_ADDR_OSC_TRIM: reg_rdata = {1'b0, trim_q};
      default: reg_rdata = 8'h00;
    endcase
  end

  assign oscillator_frequency_trim = trim_q;

  // Pin synchronisers: three stages, accept when last two agree
  reg [2:0] ts_s_q;
  reg [2:0] pen_s_q;
  reg [2:0] se_s_q;
  reg [2:0] cfa_s_q;
  reg [2:0] cfb_s_q;
  reg ts_f_q;
  reg pen_f_q;
  reg se_f_q;
  reg cfa_f_q;
  reg cfb_f_q;

  function filt;
    input [2:0] s;
    input f;
    begin
      filt = (s[1] == s[2]) ? s[2] : f;
    end
  endfunction

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ts_s_q <= 3'h0;
      pen_s_q <= 3'h0;
      se_s_q <= 3'h0;
      cfa_s_q <= 3'h0;
      cfb_s_q <= 3'h0;
      ts_f_q <= 1'b0;
      pen_f_q <= 1'b0;
      se_f_q <= 1'b0;
      cfa_f_q <= 1'b0;
      cfb_f_q <= 1'b0;
    end else begin
      ts_s_q <= {ts_s_q[1:0], timestamp_input};
      pen_s_q <= {pen_s_q[1:0], pll_enable_pin};
      se_s_q <= {se_s_q[1:0], single_ended_ref_pin};
      cfa_s_q <= {cfa_s_q[1:0], clock_config_pin_a};
      cfb_s_q <= {cfb_s_q[1:0], clock_config_pin_b};
      ts_f_q <= filt(ts_s_q, ts_f_q);
      pen_f_q <= filt(pen_s_q, pen_f_q);
      se_f_q <= filt(se_s_q, se_f_q);
      cfa_f_q <= filt(cfa_s_q, cfa_f_q);
      cfb_f_q <= filt(cfb_s_q, cfb_f_q);
    end
  end

  // Auxiliary event output generator
  wire evt_en = evt_ctrl_q[`COPOR_EVT_EN_BIT];
  wire [2:0] evt_sel = evt_ctrl_q[`COPOR_EVT_SEL_MSB:`COPOR_EVT_SEL_LSB];
  reg [1:0] div_q;
  reg evt_clk_q;
  reg evt_out_q;
  reg div_done;

  always @* begin
    case (evt_sel)
      `COPOR_SEL_UI16: div_done = 1'b1;
      `COPOR_SEL_UI32: div_done = div_q[0];
      `COPOR_SEL_UI64: div_done = &div_q;
      default: div_done = 1'b0;
    endcase
  end

  // Select changes with the output enabled are not guarded; host keeps them out
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= 2'h0;
      evt_clk_q <= 1'b0;
      evt_out_q <= 1'b0;
    end else begin
      if (!evt_en) begin
        div_q <= 2'h0;
        evt_clk_q <= 1'b0;
        evt_out_q <= 1'b0;
      end else begin
        // Divider restarts with the serializer, so the clock glitches there
        if (ser_reinit) begin
          div_q <= 2'h0;
          evt_clk_q <= 1'b0;
        end else if (ser_tick_8ui) begin
          div_q <= div_done ? 2'h0 : div_q + 2'h1;
          if (div_done) begin
            evt_clk_q <= ~evt_clk_q;
          end
        end
        case (evt_sel)
          `COPOR_SEL_UI16, `COPOR_SEL_UI32, `COPOR_SEL_UI64: evt_out_q <= evt_clk_q;
          `COPOR_SEL_TSTAMP: evt_out_q <= ts_f_q;
          default: evt_out_q <= 1'b0;
        endcase
      end
    end
  end

  assign event_output_pair_p = evt_out_q;
  assign event_output_pair_n = evt_en & ~evt_out_q;
  assign event_output_drive = evt_en;

  // PLL override multiplexer
  wire ovr_en = pll_ovr_q[`COPOR_OVR_EN_BIT];
  reg [1:0] c_sel;
  reg [1:0] d_sel;

  always @* begin
    if (ovr_en) begin
      c_sel = pll_ovr_q[`COPOR_OVR_C_MSB:`COPOR_OVR_C_LSB];
      d_sel = pll_ovr_q[`COPOR_OVR_D_MSB:`COPOR_OVR_D_LSB];
    end else begin
      c_sel = {cfb_f_q, cfa_f_q};
      d_sel = `COPOR_REF_OFF;
    end
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pll_enable <= 1'b0;
      single_ended_ref_input_sel <= 1'b0;
      divided_ref_out_c_sel <= `COPOR_REF_OFF;
      divided_ref_out_d_sel <= `COPOR_REF_OFF;
    end else begin
      pll_enable <= ovr_en ? pll_ovr_q[`COPOR_OVR_PLLEN_BIT] : pen_f_q;
      single_ended_ref_input_sel <= ovr_en ? pll_ovr_q[`COPOR_OVR_SE_BIT] : se_f_q;
      divided_ref_out_c_sel <= c_sel;
      divided_ref_out_d_sel <= (c_sel == `COPOR_REF_OFF) ? `COPOR_REF_OFF : d_sel;
    end
  end

endmodule

// ---- rtl/copor_regs.vh ----
/*
 * Register offsets, field positions, reset values and link figures of the
 * clock output and PLL override register block.
 * Assumes inclusion by its bare name; definitions only.
 */
`ifndef COPOR_REGS_VH
`define COPOR_REGS_VH

// Register addresses on the serial register port
`define COPOR_ADDR_W 15
`define COPOR_ADDR_EVT_CTRL 15'h0057
`define COPOR_ADDR_PLL_OVR 15'h0058
`define COPOR_ADDR_OSC_TRIM 15'h0059

// Reset values
`define COPOR_RST_EVT_CTRL 8'h00
`define COPOR_RST_PLL_OVR 8'h00
`define COPOR_RST_OSC_TRIM 8'h00

// Event output control fields
`define COPOR_EVT_EN_BIT 7
`define COPOR_EVT_SEL_MSB 2
`define COPOR_EVT_SEL_LSB 0
`define COPOR_EVT_WMASK 8'h87

// Event output select codes
`define COPOR_SEL_UI16 3'h0
`define COPOR_SEL_UI32 3'h1
`define COPOR_SEL_UI64 3'h2
`define COPOR_SEL_TSTAMP 3'h3

// PLL pin override fields
`define COPOR_OVR_EN_BIT 7
`define COPOR_OVR_D_MSB 5
`define COPOR_OVR_D_LSB 4
`define COPOR_OVR_C_MSB 3
`define COPOR_OVR_C_LSB 2
`define COPOR_OVR_SE_BIT 1
`define COPOR_OVR_PLLEN_BIT 0
`define COPOR_OVR_WMASK 8'hbf

// Oscillator trim field
`define COPOR_TRIM_W 7
`define COPOR_TRIM_WMASK 8'h7f

// Divided reference output codes
`define COPOR_REF_OFF 2'h0

// Serial frame: one read flag, 15 address bits, 8 data bits
`define COPOR_FRAME_BITS 5'd24
`define COPOR_HDR_BITS 5'd16

`endif

// ---- rtl/copor_spi_slave.v ----
/*
 * Serial register port slave: mode 0 frames of a read flag, a 15-bit
 * address and 8 data bits, most significant bit first.
 * Assumes the port pins are asynchronous to clk_sys and the serial clock
 * is well below a quarter of the system clock.
 */
`timescale 1ns/1ps
`include "copor_regs.vh"

module copor_spi_slave (
  // Clock and reset
  input wire clk_sys,
  input wire arst_n,
  // Serial pins
  input wire spi_sclk,
  input wire spi_cs_n,
  input wire spi_sdi,
  output wire spi_sdo,
  output wire spi_sdo_oe,
  // Register side
  output reg [14:0] reg_addr_q,
  output reg reg_wr_q,
  output reg [7:0] reg_wdata_q,
  input wire [7:0] reg_rdata
);

  reg [2:0] sclk_s_q;
  reg [2:0] cs_s_q;
  reg [2:0] sdi_s_q;
  reg sclk_f_q;
  reg cs_f_q;
  reg sdi_f_q;
  reg [4:0] cnt_q;
  reg [22:0] sh_q;
  reg [7:0] rd_sh_q;
  reg sdo_q;
  reg load_q;

  // Filtered level moves only when second and third stage agree
  wire sclk_new = (sclk_s_q[1] == sclk_s_q[2]) ? sclk_s_q[2] : sclk_f_q;
  wire cs_new = (cs_s_q[1] == cs_s_q[2]) ? cs_s_q[2] : cs_f_q;
  wire sdi_new = (sdi_s_q[1] == sdi_s_q[2]) ? sdi_s_q[2] : sdi_f_q;
  wire rise = sclk_new & ~sclk_f_q;
  wire fall = ~sclk_new & sclk_f_q;

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sclk_s_q <= 3'h0;
      cs_s_q <= 3'h7;
      sdi_s_q <= 3'h0;
      sclk_f_q <= 1'b0;
      cs_f_q <= 1'b1;
      sdi_f_q <= 1'b0;
      cnt_q <= 5'h00;
      sh_q <= 23'h000000;
      rd_sh_q <= 8'h00;
      sdo_q <= 1'b0;
      load_q <= 1'b0;
      reg_addr_q <= 15'h0000;
      reg_wr_q <= 1'b0;
      reg_wdata_q <= 8'h00;
    end else begin
      sclk_s_q <= {sclk_s_q[1:0], spi_sclk};
      cs_s_q <= {cs_s_q[1:0], spi_cs_n};
      sdi_s_q <= {sdi_s_q[1:0], spi_sdi};
      sclk_f_q <= sclk_new;
      cs_f_q <= cs_new;
      sdi_f_q <= sdi_new;
      reg_wr_q <= 1'b0;
      load_q <= 1'b0;
      if (load_q) begin
        rd_sh_q <= reg_rdata;
      end
      if (cs_new) begin
        cnt_q <= 5'h00;
        sdo_q <= 1'b0;
      end else if (rise && cnt_q < `COPOR_FRAME_BITS) begin
        sh_q <= {sh_q[21:0], sdi_new};
        cnt_q <= cnt_q + 5'h01;
        if (cnt_q == `COPOR_HDR_BITS - 5'h01) begin
          reg_addr_q <= {sh_q[13:0], sdi_new};
          load_q <= 1'b1;
        end
        // Write only when the leading flag of the frame was zero
        if (cnt_q == `COPOR_FRAME_BITS - 5'h01 && !sh_q[22]) begin
          reg_wdata_q <= {sh_q[6:0], sdi_new};
          reg_wr_q <= 1'b1;
        end
      end else if (fall && cnt_q >= `COPOR_HDR_BITS && cnt_q < `COPOR_FRAME_BITS) begin
        sdo_q <= rd_sh_q[7];
        rd_sh_q <= {rd_sh_q[6:0], 1'b0};
      end
    end
  end

  assign spi_sdo = sdo_q;
  assign spi_sdo_oe = ~cs_f_q;

endmodule

// ---- verif/copor_top_asserts.sv ----
/* Checker for copor_top port relations.
   Assumes binding to copor_top, one clock domain. */
`timescale 1ns/1ps
module copor_chk (
  // Clock and reset
  input wire clk_sys,
  input wire arst_n,
  // Observed ports
  input wire spi_cs_n,
  input wire cal_trim_wr,
  input wire [6:0] cal_trim_value,
  input wire event_output_pair_p,
  input wire event_output_pair_n,
  input wire event_output_drive,
  input wire pll_enable,
  input wire [1:0] divided_ref_out_c_sel,
  input wire [1:0] divided_ref_out_d_sel,
  input wire [6:0] oscillator_frequency_trim
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // p is a register, so allow it one cycle to clear
  property p_off_p; !event_output_drive [*2] |-> !event_output_pair_p; endproperty
  a_off_p: assert property (p_off_p) else $error("p active while disabled");
  property p_off_n; !event_output_drive |-> !event_output_pair_n; endproperty
  a_off_n: assert property (p_off_n) else $error("n active while disabled");
  property p_pair; event_output_drive |-> event_output_pair_n == !event_output_pair_p; endproperty
  a_pair: assert property (p_pair) else $error("pair legs not opposite");
  property p_rise; $rose(event_output_pair_p) |-> $past(event_output_drive); endproperty
  a_rise: assert property (p_rise) else $error("p rose while disabled");
  property p_d_c; divided_ref_out_c_sel == 2'h0 |-> divided_ref_out_d_sel == 2'h0; endproperty
  a_d_c: assert property (p_d_c) else $error("output d runs without c");
  property p_rst;
    $rose(arst_n) |-> !event_output_drive && !pll_enable && oscillator_frequency_trim == 7'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_cal; cal_trim_wr |=> oscillator_frequency_trim == $past(cal_trim_value); endproperty
  a_cal: assert property (p_cal) else $error("engine trim write lost");
  property p_hold; (spi_cs_n && !cal_trim_wr) [*8] |=> $stable(oscillator_frequency_trim); endproperty
  a_hold: assert property (p_hold) else $error("trim moved without a write");
  c_clk: cover property ($rose(event_output_pair_p));
  c_ovr: cover property (divided_ref_out_c_sel == 2'h2 && divided_ref_out_d_sel == 2'h3);
  c_cal: cover property (cal_trim_wr);
endmodule
bind copor_top copor_chk u_chk (.clk_sys, .arst_n, .spi_cs_n, .cal_trim_wr, .cal_trim_value,
  .event_output_pair_p, .event_output_pair_n, .event_output_drive, .pll_enable,
  .divided_ref_out_c_sel, .divided_ref_out_d_sel, .oscillator_frequency_trim);

// ---- verif/copor_host.sv ----
/* Serial register host model: whole 24-bit mode 0 frames.
   Assumes slow serial clock, 100 ns half period. */
`timescale 1ns/1ps
module copor_host (
  // Serial pins
  output reg spi_sclk,
  output reg spi_cs_n,
  output reg spi_sdi,
  input wire spi_sdo
);
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_sdi = 1'b0;
  end
  // Released sdi shows the inverse of its last bit, never a stale value
  task xfer(input rd, input [14:0] addr, input [7:0] wdat, output [7:0] rdat);
    reg [23:0] f;
    integer i;
    begin
      f = {rd, addr, wdat};
      spi_cs_n = 1'b0;
      #100;
      for (i = 23; i >= 0; i = i - 1) begin
        spi_sdi = f[i];
        #100 spi_sclk = 1'b1;
        if (i < 8) rdat[i] = spi_sdo;
        #100 spi_sclk = 1'b0;
      end
      #100 spi_cs_n = 1'b1;
      spi_sdi = ~spi_sdi;
      #100;
    end
  endtask
endmodule

// ---- verif/testbench.sv ----
/* Self-checking bench for copor_top.
   Assumes copor_host drives the serial pins. */
`timescale 1ns/1ps
`include "copor_regs.vh"
module testbench;
  reg clk_sys = 1'b0, arst_n = 1'b0, ser_tick_8ui = 1'b0, ser_reinit = 1'b0, ts = 1'b0;
  reg pin_en = 1'b1, pin_se = 1'b0, pin_a = 1'b1, pin_b = 1'b0, cal_wr = 1'b0;
  reg cal_en = 1'b0, cal_done = 1'b0;
  reg [6:0] cal_val = 7'h00;
  reg [1:0] tc = 2'h0;
  wire sclk, cs_n, sdi, sdo, oe, p, n, drv, pen, se;
  wire [1:0] csel, dsel;
  wire [6:0] trim;
  integer n_errors = 0, check_count = 0, cyc = 0, g, c;
  reg [7:0] r;
  copor_host host (.spi_sclk(sclk), .spi_cs_n(cs_n), .spi_sdi(sdi), .spi_sdo(sdo));
  copor_top DUT (.clk_sys(clk_sys), .arst_n(arst_n), .spi_sclk(sclk), .spi_cs_n(cs_n),
    .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe(oe), .ser_tick_8ui(ser_tick_8ui),
    .ser_reinit(ser_reinit), .timestamp_input(ts), .event_output_pair_p(p),
    .event_output_pair_n(n), .event_output_drive(drv), .pll_enable_pin(pin_en),
    .single_ended_ref_pin(pin_se), .clock_config_pin_a(pin_a), .clock_config_pin_b(pin_b),
    .oscillator_calibration_enable(cal_en), .oscillator_calibration_done(cal_done),
    .cal_trim_wr(cal_wr), .cal_trim_value(cal_val), .pll_enable(pen),
    .single_ended_ref_input_sel(se), .divided_ref_out_c_sel(csel),
    .divided_ref_out_d_sel(dsel), .oscillator_frequency_trim(trim));
  always #2.5 clk_sys = ~clk_sys;
  // Tick every 4 cycles stands for 8 UI
  always @(posedge clk_sys) begin
    #1;
    tc = tc + 2'h1;
    ser_tick_8ui = (tc == 2'h0);
    cyc = cyc + 1;
    if (cyc == 60000) begin
      n_errors = n_errors + 1;
      give_verdict;
    end
  end
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input [8*8-1:0] what, input [7:0] exp, input [7:0] got);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("BAD %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task cyc_n(input integer k);
    repeat (k) @(posedge clk_sys) #1;
  endtask
  task wr(input [14:0] a, input [7:0] d);
    begin cyc_n(1); host.xfer(1'b0, a, d, r); end
  endtask
  task rd(input [14:0] a);
    begin cyc_n(1); host.xfer(1'b1, a, 8'h00, r); end
  endtask
  task do_reset;
    begin arst_n = 1'b0; cyc_n(12); arst_n = 1'b1; cyc_n(10); end
  endtask
  // Cycles between two rises of p, 0 if none
  task rise_gap(output integer gap);
    integer k, first;
    reg prv;
    begin
      gap = 0; first = -1; prv = 1'b1;
      for (k = 0; k < 200; k = k + 1) begin
        cyc_n(1);
        if (p === 1'b1 && prv === 1'b0) begin
          if (first >= 0 && gap == 0) gap = k - first;
          first = k;
        end
        prv = p;
      end
    end
  endtask
  task t_reset;
    begin
      rd(`COPOR_ADDR_EVT_CTRL); chk("evt", `COPOR_RST_EVT_CTRL, r);
      rd(`COPOR_ADDR_PLL_OVR); chk("ovr", `COPOR_RST_PLL_OVR, r);
      rd(`COPOR_ADDR_OSC_TRIM); chk("trim", `COPOR_RST_OSC_TRIM, r);
      chk("drv", 8'h00, drv);
      chk("oe", 8'h00, oe);
      $display("test reset done");
    end
  endtask
  task t_pll;
    begin
      chk("pen", 8'h01, pen);
      chk("csel", 8'h01, csel);
      wr(`COPOR_ADDR_PLL_OVR, 8'hbb);
      chk("pen", 8'h01, pen);
      chk("se", 8'h01, se);
      chk("csel", 8'h02, csel);
      chk("dsel", 8'h03, dsel);
      rd(`COPOR_ADDR_PLL_OVR); chk("ovr", 8'hbb, r);
      wr(`COPOR_ADDR_PLL_OVR, 8'h90);
      chk("dsel", 8'h00, dsel);
      chk("pen", 8'h00, pen);
      wr(`COPOR_ADDR_PLL_OVR, 8'h3b);
      chk("csel", 8'h01, csel);
      chk("se", 8'h00, se);
      chk("dsel", 8'h00, dsel);
      pin_b = 1'b1; cyc_n(10);
      chk("csel", 8'h03, csel);
      $display("test pll done");
    end
  endtask
  task t_evt;
    begin
      for (c = 0; c < 5; c = c + 1) begin
        wr(`COPOR_ADDR_EVT_CTRL, c[7:0]);
        wr(`COPOR_ADDR_EVT_CTRL, 8'h80 | c[7:0]);
        chk("drv", 8'h01, drv);
        rise_gap(g);
        chk("gap", (c < 3) ? (8 << c) : 0, g);
        if (c == 0) begin
          // Two looks half a period apart: a running clock cannot be low at both
          ser_reinit = 1'b1; cyc_n(4);
          chk("p_rst", 8'h00, p);
          cyc_n(4);
          chk("p_rst", 8'h00, p);
          ser_reinit = 1'b0;
        end
        if (c == 3) begin
          ts = 1'b1; cyc_n(10); chk("ts_hi", 8'h01, p);
          ts = 1'b0; cyc_n(10); chk("ts_lo", 8'h00, p);
        end
        wr(`COPOR_ADDR_EVT_CTRL, 8'h00);
        chk("p_off", 8'h00, p);
      end
      $display("test event output done");
    end
  endtask
  task t_trim;
    begin
      // Reserved bit kept zero by the host
      wr(`COPOR_ADDR_OSC_TRIM, 8'h7f);
      rd(`COPOR_ADDR_OSC_TRIM); chk("trim", 8'h7f, r);
      chk("trim_o", 8'h7f, trim);
      // Host stays off the port while the engine runs
      cal_en = 1'b1; cal_val = 7'h15; cal_wr = 1'b1; cyc_n(1);
      cal_wr = 1'b0; cal_done = 1'b1; cyc_n(1);
      chk("cal", 8'h15, trim);
      rd(15'h005a); chk("unmap", 8'h00, r);
      do_reset;
      rd(`COPOR_ADDR_OSC_TRIM); chk("trim", 8'h00, r);
      $display("test trim done");
    end
  endtask
  initial begin
    do_reset;
    t_reset;
    t_pll;
    t_evt;
    t_trim;
    give_verdict;
  end
endmodule
